// ### rtl/irs_pkg.sv
/*
  irs_pkg: register offsets, field positions, reset values, timing counts
  and the sequencer state type of the interrupt and reset-cause block.
  assumes a 125 MHz pclk and four pclk phases per instruction cycle.
*/
package irs_pkg;

  localparam int          PC_W          = 13;
  localparam int          STACK_DEPTH   = 8;
  localparam int          SP_W          = 3;

  localparam logic [7:0]  OFF_PWR       = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_IRQ_CONTROL_REG    = 8'h08;
  localparam logic [7:0]  OFF_OPTION    = 8'h0C;
  localparam logic [7:0]  OFF_PFLAG     = 8'h10;
  localparam logic [7:0]  OFF_PEN       = 8'h14;
  localparam logic [7:0]  OFF_PC        = 8'h18;

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR   = 13'h0004;

  localparam logic [7:0]  STATUS_POR    = 8'h18;
  localparam logic [7:0]  STATUS_KEEP_MASTER_CLEAR_RESET = 8'h1F;
  localparam logic [7:0]  STATUS_KEEP_WDT  = 8'h0F;
  localparam logic [7:0]  STATUS_SW_MASK   = 8'hE7;
  localparam int          STAT_TO_BIT   = 4;
  localparam int          STAT_PD_BIT   = 3;

  localparam int          PWR_OT_BIT    = 2;
  localparam int          PWR_POR_BIT   = 1;
  localparam logic        PWR_OT_POR    = 1'b1;
  localparam logic        PWR_POR_POR   = 1'b0;

  localparam logic [7:0]  IRQ_CONTROL_REG_POR    = 8'h00;
  localparam int          IC_GIE        = 7;
  localparam int          IC_PERIPH_IRQ_ENABLE       = 6;
  localparam int          IC_T0IE       = 5;
  localparam int          IC_EXT_EDGE_ENABLE       = 4;
  localparam int          IC_IOCE       = 3;
  localparam int          IC_T0IF       = 2;
  localparam int          IC_EXT_EDGE_FLAG       = 1;
  localparam int          IC_IOCF       = 0;

  localparam int          OPT_EDGE_BIT  = 0;
  localparam int          OPT_ANA_BIT   = 1;
  localparam logic [1:0]  OPTION_POR    = 2'h3;

  localparam logic [1:0]  Q1_PHASE      = 2'h0;
  localparam logic [1:0]  LAT_EXTRA_TCY = 2'h2;

  typedef enum logic [1:0] {
    IRS_RUN     = 2'b00,
    IRS_LATENCY = 2'b01,
    IRS_SLEEP   = 2'b10
  } irs_state_t;

endpackage

// ### rtl/irs_sync.sv
/*
  irs_sync: two-stage synchroniser for one level.
  assumes the input may change at any time relative to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module irs_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // irs_sync
`default_nettype wire

// ### rtl/irs_top.sv
/*
  irs_top: interrupt control, vectoring, sleep/wake and reset-cause flags
  with an APB slave for its registers.
  assumes core event inputs are one-pclk pulses synchronous to pclk and
  that presetn low is the power-on reset.
*/
// How it works
// - power-on: pc zero, status 0001 1xxx, power-up flag cleared; watchdog 0000 uuuu
// - master clear awake: pc zero, upper three status bits cleared
// - master clear asleep: pc zero, timeout high, power-down low
// - watchdog wake: pc plus one, timeout and power-down both low
// - interrupt wake: pc plus one, timeout high, power-down low
// - wake with global enable: run next instruction, then vector to 0004h
// - unimplemented status and power control bits read zero
// - overtemperature reset clears bit 2; software writes it back to one
// - power-on clears bit 1; software sets it back to one
// - global enable gates every individually enabled interrupt
// - every reset clears the global enable
// - taking an interrupt clears enable, pushes return, loads 0004h
// - events during service still set flags but do not vector
// - interrupts skipped after enable cleared stay pending until re-enabled
// - return instruction pops address, restores context, sets enable
// - pin event to vector takes three to four instruction cycles
// - external pin edge polarity chosen by the polarity select bit
// - valid edge sets external flag; its enable gates the interrupt
// - external edge wakes from sleep when its enable is set
// - analog-selected pin reads zero and never interrupts
// - power-on sets both power-down and timeout flags
// - peripheral interrupts also need the peripheral enable bit
`timescale 1ns/100ps
`default_nettype none
module irs_top
  import irs_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  input  wire logic            port_a_bit2,
  input  wire logic            master_clear_reset,
  input  wire logic            wdt_timeout,
  input  wire logic            overtemp_reset,
  input  wire logic            instr_retire,
  input  wire logic            sleep_instr,
  input  wire logic            return_from_irq_instr,
  input  wire logic            tmr0_overflow,
  input  wire logic            pin_change_irq,
  input  wire logic [7:0]      periph_irq_set,
  output logic [PC_W-1:0]      pc_out,
  output logic                 irq_vectored,
  output logic                 ctx_restore,
  output logic                 core_reset,
  output logic                 sleep_active,
  output logic                 port_a_bit2_rd
);

  typedef struct packed {
    logic [7:0]                       status;
    logic                             ot_flag;
    logic                             por_flag;
    logic [7:0]                       irq_control_reg;
    logic [1:0]                       option;
    logic [7:0]                       pflag;
    logic [7:0]                       pen;
    logic [PC_W-1:0]                  pc;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0]                  sp;
    irs_state_t                       state;
    logic [1:0]                       lat_cnt;
    logic [1:0]                       qph;
    logic                             pin_prev;
    logic [31:0]                      rdata;
    logic                             slverr;
    logic                             vec_pulse;
    logic                             rst_pulse;
    logic                             restore_pulse;
  } irs_regs_t;

  irs_regs_t q;
  irs_regs_t d;

  logic pin_digital;
  logic pin_sync;
  logic edge_seen;
  logic q1;
  logic irq_req;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [7:0] wbyte;

  assign pin_digital = port_a_bit2 & ~q.option[OPT_ANA_BIT];

  irs_sync u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (pin_digital),
    .dout  (pin_sync)
  );

  assign pready   = psel & penable;
  assign prdata   = q.rdata;
  assign pslverr  = q.slverr & psel & penable;
  assign pc_out   = q.pc;
  assign irq_vectored = q.vec_pulse;
  assign ctx_restore  = q.restore_pulse;
  assign core_reset   = q.rst_pulse;
  assign sleep_active = (q.state == IRS_SLEEP);
  assign port_a_bit2_rd = pin_sync;

  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign wbyte    = pwdata[7:0];

  always_comb begin
    case (paddr)
      OFF_PWR, OFF_STATUS, OFF_IRQ_CONTROL_REG, OFF_OPTION,
      OFF_PFLAG, OFF_PEN, OFF_PC: mapped = 1'b1;
      default:                    mapped = 1'b0;
    endcase
  end

  // edge select on the synchronised pin
  assign edge_seen = q.option[OPT_EDGE_BIT] ? (pin_sync & ~q.pin_prev)
                                            : (~pin_sync & q.pin_prev);

  // request from any individually enabled source
  assign irq_req = (q.irq_control_reg[IC_T0IE] & q.irq_control_reg[IC_T0IF])
                 | (q.irq_control_reg[IC_EXT_EDGE_ENABLE] & q.irq_control_reg[IC_EXT_EDGE_FLAG])
                 | (q.irq_control_reg[IC_IOCE] & q.irq_control_reg[IC_IOCF])
                 | (q.irq_control_reg[IC_PERIPH_IRQ_ENABLE] & (|(q.pflag & q.pen)));

  assign q1 = (q.qph == Q1_PHASE);

  always_comb begin
    d               = q;
    d.vec_pulse     = 1'b0;
    d.rst_pulse     = 1'b0;
    d.restore_pulse = 1'b0;
    d.qph           = q.qph + 2'h1;
    d.pin_prev      = pin_sync;

    // register reads, sampled in the setup phase
    if (rd_setup) begin
      d.slverr = ~mapped;
      case (paddr)
        OFF_PWR:    d.rdata = {29'h0, q.ot_flag, q.por_flag, 1'b0};
        OFF_STATUS: d.rdata = {24'h0, q.status};
        OFF_IRQ_CONTROL_REG: d.rdata = {24'h0, q.irq_control_reg};
        OFF_OPTION: d.rdata = {30'h0, q.option};
        OFF_PFLAG:  d.rdata = {24'h0, q.pflag};
        OFF_PEN:    d.rdata = {24'h0, q.pen};
        OFF_PC:     d.rdata = {19'h0, q.pc};
        default:    d.rdata = 32'h0;
      endcase
    end

    // register writes at the access edge
    if (wr_acc) begin
      case (paddr)
        OFF_PWR: begin
          d.ot_flag  = wbyte[PWR_OT_BIT];
          d.por_flag = wbyte[PWR_POR_BIT];
        end
        OFF_STATUS: d.status = (q.status & ~STATUS_SW_MASK)
                             | (wbyte & STATUS_SW_MASK);
        OFF_IRQ_CONTROL_REG: d.irq_control_reg = wbyte;
        OFF_OPTION: d.option = wbyte[1:0];
        OFF_PFLAG:  d.pflag  = wbyte;
        OFF_PEN:    d.pen    = wbyte;
        default:    d.irq_control_reg = d.irq_control_reg;
      endcase
    end

    // hardware flag sets win over a software clear in the same cycle
    if (edge_seen) begin
      d.irq_control_reg[IC_EXT_EDGE_FLAG] = 1'b1;
    end
    if (tmr0_overflow) begin
      d.irq_control_reg[IC_T0IF] = 1'b1;
    end
    if (pin_change_irq) begin
      d.irq_control_reg[IC_IOCF] = 1'b1;
    end
    d.pflag = d.pflag | periph_irq_set;

    // instruction flow and interrupt sequencing
    case (q.state)
      IRS_RUN: begin
        if (instr_retire) begin
          d.pc = q.pc + 13'h0001;
        end
        if (return_from_irq_instr) begin
          d.sp  = q.sp - 3'h1;
          d.pc  = q.stack[q.sp - 3'h1];
          d.irq_control_reg[IC_GIE] = 1'b1;
          d.restore_pulse  = 1'b1;
        end else if (sleep_instr) begin
          d.state = IRS_SLEEP;
          d.status[STAT_TO_BIT] = 1'b1;
          d.status[STAT_PD_BIT] = 1'b0;
        end else if (q1 && irq_req && q.irq_control_reg[IC_GIE]) begin
          d.state   = IRS_LATENCY;
          d.lat_cnt = 2'h0;
        end
      end
      IRS_LATENCY: begin
        if (instr_retire) begin
          d.pc = q.pc + 13'h0001;
        end
        if (!q.irq_control_reg[IC_GIE]) begin
          d.state = IRS_RUN;
        end else if (q1) begin
          if (q.lat_cnt == LAT_EXTRA_TCY - 2'h1) begin
            d.stack[q.sp]    = instr_retire ? q.pc + 13'h0001 : q.pc;
            d.sp             = q.sp + 3'h1;
            d.pc             = IRQ_VECTOR;
            d.irq_control_reg[IC_GIE] = 1'b0;
            d.vec_pulse      = 1'b1;
            d.state          = IRS_RUN;
          end else begin
            d.lat_cnt = q.lat_cnt + 2'h1;
          end
        end
      end
      IRS_SLEEP: begin
        if (wdt_timeout) begin
          d.pc    = q.pc + 13'h0001;
          d.status[STAT_TO_BIT] = 1'b0;
          d.status[STAT_PD_BIT] = 1'b0;
          d.state = IRS_RUN;
        end else if (irq_req) begin
          d.pc    = q.pc + 13'h0001;
          d.status[STAT_TO_BIT] = 1'b1;
          d.status[STAT_PD_BIT] = 1'b0;
          d.state   = q.irq_control_reg[IC_GIE] ? IRS_LATENCY : IRS_RUN;
          d.lat_cnt = 2'h0;
        end
      end
      default: begin
        d.state = IRS_RUN;
      end
    endcase

    // warm resets override the pc, stack pointer, global enable, state and vector pulse set above
    if (overtemp_reset || master_clear_reset ||
        (wdt_timeout && q.state != IRS_SLEEP)) begin
      d.pc             = RESET_VECTOR;
      d.sp             = 3'h0;
      d.irq_control_reg[IC_GIE] = 1'b0;
      d.state          = IRS_RUN;
      d.rst_pulse      = 1'b1;
      d.vec_pulse      = 1'b0;
      if (overtemp_reset) begin
        d.ot_flag = 1'b0;
      end
      if (master_clear_reset && q.state == IRS_SLEEP) begin
        d.status = q.status & STATUS_KEEP_MASTER_CLEAR_RESET;
        d.status[STAT_TO_BIT] = 1'b1;
        d.status[STAT_PD_BIT] = 1'b0;
      end else if (master_clear_reset) begin
        d.status = q.status & STATUS_KEEP_MASTER_CLEAR_RESET;
      end else if (wdt_timeout) begin
        d.status = q.status & STATUS_KEEP_WDT;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.status   <= STATUS_POR;
      q.ot_flag  <= PWR_OT_POR;
      q.por_flag <= PWR_POR_POR;
      q.irq_control_reg   <= IRQ_CONTROL_REG_POR;
      q.option   <= OPTION_POR;
      q.pc       <= RESET_VECTOR;
      q.state    <= IRS_RUN;
    end else begin
      q <= d;
    end
  end

endmodule // irs_top
`default_nettype wire

// ### test/irs_chk.sv
/* irs_chk: port assertions of irs_top. assumes one pclk domain. */
`timescale 1ns/100ps
`default_nettype none
module irs_chk
  import irs_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [7:0]      paddr,
  input wire logic            pslverr,
  input wire logic            master_clear_reset,
  input wire logic            wdt_timeout,
  input wire logic            overtemp_reset,
  input wire logic            return_from_irq_instr,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic            irq_vectored,
  input wire logic            ctx_restore,
  input wire logic            core_reset,
  input wire logic            sleep_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_left_sleep;
    ##1 !sleep_active;
  endsequence
  vec_pc_a: assert property (irq_vectored |-> pc_out == IRQ_VECTOR)
    else $error("vector without pc 0004");
  vec_once_a: assert property (irq_vectored |=> !irq_vectored)
    else $error("vector pulse too long");
  vec_awake_a: assert property (irq_vectored |-> !sleep_active)
    else $error("vector while asleep");
  master_clear_reset_pc_a: assert property (master_clear_reset |=> core_reset
    && pc_out == RESET_VECTOR) else $error("master clear pc");
  master_clear_reset_sleep_a: assert property (sleep_active && master_clear_reset
    |-> s_left_sleep ##0 pc_out == RESET_VECTOR) else $error("clear in sleep");
  wdt_wake_a: assert property (sleep_active && wdt_timeout && !overtemp_reset
    && !master_clear_reset |-> s_left_sleep ##0 pc_out == $past(pc_out) + 1'b1)
    else $error("watchdog wake pc");
  wdt_rst_a: assert property (!sleep_active && wdt_timeout |=> pc_out == 0)
    else $error("watchdog reset pc");
  ot_rst_a: assert property (overtemp_reset |=> core_reset && pc_out == 0)
    else $error("overtemp reset");
  ret_ctx_a: assert property (return_from_irq_instr && !master_clear_reset
    && !wdt_timeout && !overtemp_reset |=> ctx_restore) else $error("no restore");
  bad_addr_a: assert property (psel && penable && paddr > OFF_PC |-> pslverr)
    else $error("unmapped not refused");
endmodule // irs_chk
bind irs_top irs_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .master_clear_reset, .wdt_timeout, .overtemp_reset, .return_from_irq_instr,
  .pc_out, .irq_vectored, .ctx_restore, .core_reset, .sleep_active);
`default_nettype wire

// ### test/irs_core_model.sv
/* irs_core_model: core stand-in, one retire per four pclk while awake,
   return from service one pclk after isr_exit. assumes pclk, presetn. */
`timescale 1ns/100ps
`default_nettype none
module irs_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sleep_active,
  input  wire logic isr_exit,
  output logic      instr_retire,
  output logic      return_from_irq_instr
);
  logic [1:0] ph_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q                  <= 2'h0;
      instr_retire          <= 1'b0;
      return_from_irq_instr <= 1'b0;
    end else begin
      ph_q                  <= ph_q + 2'h1;
      instr_retire          <= (ph_q == 2'h3) && !sleep_active;
      return_from_irq_instr <= isr_exit;
    end
  end
endmodule // irs_core_model
`default_nettype wire

// ### test/irs_top_tb.sv
/* irs_top_tb: register, reset-cause, sleep and interrupt scenarios.
   assumes irs_top, irs_core_model and the bound irs_chk. */
`timescale 1ns/100ps
`default_nettype none
module irs_top_tb;
  import irs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
  logic pslverr, port_a_bit2 = 0, master_clear_reset = 0, wdt_timeout = 0;
  logic overtemp_reset = 0, sleep_instr = 0, isr_exit = 0, instr_retire;
  logic tmr0_overflow = 0, pin_change_irq = 0;
  logic return_from_irq_instr, irq_vectored, ctx_restore, core_reset;
  logic sleep_active, port_a_bit2_rd, err_q;
  logic [7:0]      paddr = 0, periph_irq_set = 0;
  logic [31:0]     pwdata = 0, prdata, r;
  logic [PC_W-1:0] pc_out;
  int mismatches = 0, cmp_count = 0, cyc = 0, n;
  irs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .port_a_bit2, .master_clear_reset,
    .wdt_timeout, .overtemp_reset, .instr_retire, .sleep_instr,
    .return_from_irq_instr, .tmr0_overflow, .pin_change_irq,
    .periph_irq_set, .pc_out, .irq_vectored, .ctx_restore,
    .core_reset, .sleep_active, .port_a_bit2_rd);
  irs_core_model core (.pclk, .presetn, .sleep_active, .isr_exit,
    .instr_retire, .return_from_irq_instr);
  always #4 pclk = ~pclk;
  task test_done;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic wait_for(ref logic s, input int lim);
    n = 0;
    do begin @(posedge pclk); n++; end while (s !== 1'b1 && n < lim);
    chk(n < lim, 1'b1);
  endtask
  task no_vec(input int k);
    n = 0;
    repeat (k) begin
      @(posedge pclk);
      if (irq_vectored !== 1'b0) n++;
    end
    chk(n, 0);
  endtask
  task idle(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task t_reset;
    rd(OFF_PWR, 32'h04);
    rd(OFF_STATUS, {24'h0, STATUS_POR});
    rd(OFF_IRQ_CONTROL_REG, 32'h00);
    rd(8'h1C, 32'h0);
    chk(err_q, 1'b1);
  endtask
  task t_pwr;
    apb(1'b1, OFF_PWR, 32'hFF);
    rd(OFF_PWR, 32'h06);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h80);
    @(posedge pclk) overtemp_reset <= 1'b1;
    @(posedge pclk) overtemp_reset <= 1'b0;
    rd(OFF_PWR, 32'h02);
    apb(1'b1, OFF_PWR, 32'h06);
    rd(OFF_PWR, 32'h06);
    rd(OFF_IRQ_CONTROL_REG, 32'h00);
  endtask
  task t_ext_rise;
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h90);
    port_a_bit2 <= 1'b1;
    idle(20);
    chk(port_a_bit2_rd, 1'b0);
    rd(OFF_IRQ_CONTROL_REG, 32'h90);
    port_a_bit2 <= 1'b0;
    apb(1'b1, OFF_OPTION, 32'h01);
    idle(4);
    port_a_bit2 <= 1'b1;
    wait_for(irq_vectored, 18);
    chk(pc_out, IRQ_VECTOR);
    chk(port_a_bit2_rd, 1'b1);
    rd(OFF_IRQ_CONTROL_REG, 32'h12);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h10);
    @(posedge pclk) isr_exit <= 1'b1;
    @(posedge pclk) isr_exit <= 1'b0;
    wait_for(ctx_restore, 8);
    rd(OFF_IRQ_CONTROL_REG, 32'h90);
  endtask
  task t_ext_fall;
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h10);
    apb(1'b1, OFF_OPTION, 32'h00);
    port_a_bit2 <= 1'b0;
    no_vec(24);
    rd(OFF_IRQ_CONTROL_REG, 32'h12);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h92);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h12);
    no_vec(16);
    rd(OFF_IRQ_CONTROL_REG, 32'h12);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h92);
    wait_for(irq_vectored, 18);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h00);
  endtask
  task t_sleep;
    @(posedge pclk) sleep_instr <= 1'b1;
    @(posedge pclk) sleep_instr <= 1'b0;
    rd(OFF_STATUS, 32'h10);
    chk(r & 32'h18, 32'h10);
    @(posedge pclk) wdt_timeout <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b0;
    rd(OFF_STATUS, 32'h00);
    chk(r & 32'h18, 32'h00);
    @(posedge pclk) sleep_instr <= 1'b1;
    @(posedge pclk) sleep_instr <= 1'b0;
    @(posedge pclk) master_clear_reset <= 1'b1;
    @(posedge pclk) master_clear_reset <= 1'b0;
    rd(OFF_STATUS, 32'h10);
    chk(r & 32'hF8, 32'h10);
    apb(1'b1, OFF_STATUS, 32'hE0);
    @(posedge pclk) master_clear_reset <= 1'b1;
    @(posedge pclk) master_clear_reset <= 1'b0;
    rd(OFF_STATUS, 32'h10);
    chk(r & 32'hF8, 32'h10);
    apb(1'b1, OFF_STATUS, 32'hE7);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h80);
    @(posedge pclk) wdt_timeout <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b0;
    rd(OFF_STATUS, 32'h07);
    rd(OFF_IRQ_CONTROL_REG, 32'h00);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h90);
    port_a_bit2 <= 1'b1;
    idle(4);
    @(posedge pclk) sleep_instr <= 1'b1;
    @(posedge pclk) sleep_instr <= 1'b0;
    port_a_bit2 <= 1'b0;
    wait_for(irq_vectored, 24);
    rd(OFF_STATUS, 32'h17);
  endtask
  task t_periph;
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h00);
    apb(1'b1, OFF_PEN, 32'h01);
    @(posedge pclk) periph_irq_set <= 8'h01;
    @(posedge pclk) periph_irq_set <= 8'h00;
    rd(OFF_PFLAG, 32'h01);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'h80);
    no_vec(16);
    apb(1'b1, OFF_IRQ_CONTROL_REG, 32'hC0);
    wait_for(irq_vectored, 18);
    @(posedge pclk) {tmr0_overflow, pin_change_irq} <= 2'b11;
    @(posedge pclk) {tmr0_overflow, pin_change_irq} <= 2'b00;
    rd(OFF_IRQ_CONTROL_REG, 32'h45);
    apb(1'b1, OFF_PFLAG, 32'h00);
    rd(OFF_PFLAG, 32'h00);
  endtask
  initial begin
    idle(8);
    presetn <= 1'b1;
    t_reset;
    t_pwr;
    t_ext_rise;
    t_ext_fall;
    t_sleep;
    t_periph;
    test_done;
  end
endmodule // irs_top_tb
`default_nettype wire
